// ### i2crs_device.sv
// Register slave end of the two-wire control port
`timescale 1ns/1ps
module i2crs_device
    import i2crs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    i2crs_if.dev bus,
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic mode_sel_pin,
    output logic two_wire_sel,
    output logic [7:0] reg_idx,
    input wire logic reg_idx_ok,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic [7:0] reg_wr_idx,
    output logic [7:0] reg_wr_data
);

    logic [4:0] pin_raw;
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    logic [1:0] strap_cnt_q;
    logic [1:0] strap_cnt_d;
    logic strap_done_q;
    logic strap_done_d;
    logic sel_q;
    logic sel_d;
    logic [1:0] adr_q;
    logic [1:0] adr_d;
    logic [6:0] own_addr;

    i2crs_dst_t st_q;
    i2crs_dst_t st_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic [7:0] idx_q;
    logic [7:0] idx_d;
    logic oe_q;
    logic oe_d;
    logic wr_q;
    logic wr_d;
    logic [7:0] wr_idx_q;
    logic [7:0] wr_idx_d;
    logic [7:0] wr_data_q;
    logic [7:0] wr_data_d;

    // Two-stage synchronisers on every pin, then edge history
    assign pin_raw = {bus.scl, bus.sda, mode_sel_pin, addr_strap_bit1, addr_strap_bit0};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_q <= 5'h1F;
            s2_q <= 5'h1F;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            scl_prev_q <= s2_q[4];
            sda_prev_q <= s2_q[3];
        end
    end

    // Link events; sampling at 125 MHz leaves ample margin at 400 kHz
    // (RULE_15) edge and condition detection
    assign scl_s = s2_q[4];
    assign sda_s = s2_q[3];
    assign scl_rise = scl_s && !scl_prev_q;
    assign scl_fall = !scl_s && scl_prev_q;
    assign start_ev = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign stop_ev = scl_s && scl_prev_q && !sda_prev_q && sda_s;

    // Strap capture shortly after reset release, never again
    always_comb
    begin
        strap_cnt_d = strap_cnt_q;
        strap_done_d = strap_done_q;
        sel_d = sel_q;
        adr_d = adr_q;
        if (!strap_done_q)
        begin
            if (strap_cnt_q == STRAP_WAIT)
            begin
                strap_done_d = 1'b1;
                // (RULE_16) mode pin low selects
                sel_d = !s2_q[2];
                // (RULE_02) strap address bits
                adr_d = s2_q[1:0];
            end
            else
            begin
                strap_cnt_d = strap_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            strap_cnt_q <= 2'h0;
            strap_done_q <= 1'b0;
            sel_q <= 1'b0;
            adr_q <= 2'h0;
        end
        else
        begin
            strap_cnt_q <= strap_cnt_d;
            strap_done_q <= strap_done_d;
            sel_q <= sel_d;
            adr_q <= adr_d;
        end
    end

    // (RULE_01) fixed prefix plus straps
    assign own_addr = {SLAVE_ADDR_PREFIX, adr_q};

    // Protocol engine: slave only, never makes start or stop
    // (RULE_04) receiver and transmitter roles
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        idx_d = idx_q;
        oe_d = oe_q;
        wr_d = 1'b0;
        wr_idx_d = wr_idx_q;
        wr_data_d = wr_data_q;
        if (!sel_q || stop_ev)
        begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
        end
        else if (start_ev)
        begin
            // (RULE_05) master opens every frame
            st_d = ST_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end
        else
        begin
            unique case (st_q)
                ST_IDLE:
                begin
                    oe_d = 1'b0;
                end
                ST_ADDR, ST_IDX, ST_DATA:
                begin
                    if (scl_rise && cnt_q != BIT_CNT_FULL)
                    begin
                        // (RULE_10) shift in MSB first
                        sh_d = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                        if (st_q == ST_IDX && cnt_q == BIT_CNT_FULL - 4'h1)
                        begin
                            // (RULE_11) keep written index
                            idx_d = {sh_q[6:0], sda_s};
                        end
                    end
                    else if (scl_fall && cnt_q == BIT_CNT_FULL)
                    begin
                        cnt_d = 4'h0;
                        st_d = ST_IDLE;
                        if (st_q == ST_ADDR)
                        begin
                            // (RULE_03) acknowledge own address only
                            if (sh_q[7:1] == own_addr)
                            begin
                                oe_d = 1'b1;
                                st_d = ST_ADDR_ACK;
                            end
                        end
                        // (RULE_09) undefined index left unacknowledged
                        else if (reg_idx_ok)
                        begin
                            // (RULE_06) acknowledge index and data
                            oe_d = 1'b1;
                            st_d = (st_q == ST_IDX) ? ST_IDX_ACK : ST_DATA_ACK;
                            if (st_q == ST_DATA)
                            begin
                                // (RULE_07) one write per data byte
                                wr_d = 1'b1;
                                wr_idx_d = idx_q;
                                wr_data_d = sh_q;
                                // (RULE_08) step to next register
                                idx_d = idx_q + 8'h01;
                            end
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (sh_q[0])
                        begin
                            // (RULE_12) send the indexed byte
                            sh_d = reg_rdata;
                            oe_d = !reg_rdata[7];
                            cnt_d = 4'h1;
                            st_d = ST_TX;
                        end
                        else
                        begin
                            oe_d = 1'b0;
                            cnt_d = 4'h0;
                            st_d = ST_IDX;
                        end
                    end
                end
                ST_IDX_ACK, ST_DATA_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_d = 1'b0;
                        cnt_d = 4'h0;
                        st_d = ST_DATA;
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_q == BIT_CNT_FULL)
                        begin
                            oe_d = 1'b0;
                            st_d = ST_TX_ACK;
                        end
                        else
                        begin
                            // (RULE_10) shift out MSB first
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = !sh_q[6];
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_rise)
                    begin
                        if (!sda_s)
                        begin
                            idx_d = idx_q + 8'h01;
                        end
                        else
                        begin
                            // (RULE_14) NACK: release and wait
                            st_d = ST_IDLE;
                        end
                    end
                    else if (scl_fall)
                    begin
                        sh_d = reg_rdata;
                        oe_d = !reg_rdata[7];
                        cnt_d = 4'h1;
                        st_d = ST_TX;
                    end
                end
                default:
                begin
                    st_d = ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            idx_q <= IDX_RESET;
            oe_q <= 1'b0;
            wr_q <= 1'b0;
            wr_idx_q <= 8'h00;
            wr_data_q <= 8'h00;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            idx_q <= idx_d;
            oe_q <= oe_d;
            wr_q <= wr_d;
            wr_idx_q <= wr_idx_d;
            wr_data_q <= wr_data_d;
        end
    end

    // Outputs; the data pin only ever pulls low
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = oe_q;
    assign two_wire_sel = sel_q;
    assign reg_idx = idx_q;
    assign reg_wr = wr_q;
    assign reg_wr_idx = wr_idx_q;
    assign reg_wr_data = wr_data_q;

endmodule

// ### i2crs_pkg.sv
// Constants and types for the two-wire register slave port and its bus master
// How it works
// (RULE_01) Address top five bits fixed to 10000.
// (RULE_02) Low two address bits come from straps.
// (RULE_03) Answer only our own seven-bit address.
// (RULE_04) Slave only: receive writes, transmit reads.
// (RULE_05) Master makes every start, stop, address.
// (RULE_06) Write: address, index, data, all acknowledged.
// (RULE_07) Single or several data bytes per write.
// (RULE_08) Index steps by one per data byte.
// (RULE_09) Undefined register index gets no acknowledge.
// (RULE_10) Bytes are eight bits, MSB first.
// (RULE_11) Written index selects the later read.
// (RULE_12) Read: index, repeated start, read, NACK.
// (RULE_13) Same slave address after repeated start.
// (RULE_14) After NACK release data, await stop/start.
// (RULE_15) Works at 100 kHz and 400 kHz.
// (RULE_16) Select pin low at reset picks two-wire.
package i2crs_pkg;

    // System clock period
    localparam int CLK_PERIOD_NS = 8;
    // Fixed upper part of the slave address
    localparam logic [4:0] SLAVE_ADDR_PREFIX = 5'h10;
    // Bits in one byte on the wire, as a counter value
    localparam logic [3:0] BIT_CNT_FULL = 4'h8;
    // Highest serial clock rate served
    localparam int SCL_FAST_MAX_KHZ = 400;
    // Least low time of the serial clock, fast mode
    localparam int T_LOW_MIN_NS = 1300;
    // Master quarter bit: half of the least low time, rounded up
    localparam int QTR_CYC = (T_LOW_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Cycles after reset release before the straps are caught
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    // Register index after reset
    localparam logic [7:0] IDX_RESET = 8'h00;

    // Slave states
    typedef enum logic [8:0] {
        ST_IDLE     = 9'h001,
        ST_ADDR     = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_IDX      = 9'h008,
        ST_IDX_ACK  = 9'h010,
        ST_DATA     = 9'h020,
        ST_DATA_ACK = 9'h040,
        ST_TX       = 9'h080,
        ST_TX_ACK   = 9'h100
    } i2crs_dst_t;

    // Master states
    typedef enum logic [3:0] {
        H_IDLE  = 4'h1,
        H_START = 4'h2,
        H_BYTE  = 4'h4,
        H_STOP  = 4'h8
    } i2crs_hst_t;

endpackage

// ### i2crs_if.sv
// Two-wire link between the bus master and the register slave
`timescale 1ns/1ps
interface i2crs_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wires with pull-up
    assign scl = !(host_scl_oe && !host_scl_o);
    assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                  output host_sda_o, output host_sda_oe);
endinterface

// ### i2crs_host.sv
// Bus master end: single-byte register writes and reads over the two-wire link
`timescale 1ns/1ps
module i2crs_host
    import i2crs_pkg::*;
#(
    parameter int QTR_CYCLES = QTR_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    i2crs_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [6:0] cmd_addr,
    input wire logic [7:0] cmd_idx,
    input wire logic [7:0] cmd_wdata,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic rsp_nack
);

    // Quarter bit must fit the divider and keep the rate legal
    if (QTR_CYCLES < 1 || QTR_CYCLES > 65535 ||
        QTR_CYCLES * 4 * CLK_PERIOD_NS < 1000000 / SCL_FAST_MAX_KHZ)
    begin : g_chk
        $error("QTR_CYCLES out of range");
    end

    logic sda_s1_q;
    logic sda_s_q;
    logic [15:0] qcnt_q;
    logic [15:0] qcnt_d;
    logic tick;
    i2crs_hst_t st_q;
    i2crs_hst_t st_d;
    logic [1:0] ph_q;
    logic [1:0] ph_d;
    logic [2:0] step_q;
    logic [2:0] step_d;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [7:0] rx_q;
    logic [7:0] rx_d;
    logic scl_oe_q;
    logic scl_oe_d;
    logic sda_oe_q;
    logic sda_oe_d;
    logic rd_q;
    logic rd_d;
    logic [6:0] addr_q;
    logic [6:0] addr_d;
    logic [7:0] idx_q;
    logic [7:0] idx_d;
    logic [7:0] wd_q;
    logic [7:0] wd_d;
    logic ready_q;
    logic ready_d;
    logic rv_q;
    logic rv_d;
    logic nack_q;
    logic nack_d;
    logic rdbyte;

    // Byte sent at each step of a transfer
    // (RULE_13) same address after repeated start
    function automatic logic [7:0] byte_for(input logic [2:0] step, input logic rd,
                                            input logic [6:0] a, input logic [7:0] ix,
                                            input logic [7:0] wd);
        logic [7:0] b;
        b = {a, 1'b0};
        if (step == 3'h1)
            b = ix;
        else if (step == 3'h2)
            b = rd ? {a, 1'b1} : wd;
        return b;
    endfunction

    // Data line synchroniser
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sda_s1_q <= 1'b1;
            sda_s_q <= 1'b1;
        end
        else
        begin
            sda_s1_q <= bus.sda;
            sda_s_q <= sda_s1_q;
        end
    end

    assign tick = (qcnt_q == 16'(QTR_CYCLES - 1));
    assign rdbyte = (step_q == 3'h3);

    // Sequencer, advancing one quarter bit per tick
    // (RULE_05) master makes all conditions
    always_comb
    begin
        qcnt_d = tick ? 16'h0000 : qcnt_q + 16'h0001;
        st_d = st_q;
        ph_d = ph_q;
        step_d = step_q;
        bit_d = bit_q;
        tx_d = tx_q;
        rx_d = rx_q;
        scl_oe_d = scl_oe_q;
        sda_oe_d = sda_oe_q;
        rd_d = rd_q;
        addr_d = addr_q;
        idx_d = idx_q;
        wd_d = wd_q;
        ready_d = ready_q;
        rv_d = 1'b0;
        nack_d = nack_q;
        unique case (st_q)
            H_IDLE:
            begin
                if (cmd_valid && ready_q)
                begin
                    ready_d = 1'b0;
                    rd_d = cmd_read;
                    addr_d = cmd_addr;
                    idx_d = cmd_idx;
                    wd_d = cmd_wdata;
                    nack_d = 1'b0;
                    step_d = 3'h0;
                    ph_d = 2'h0;
                    qcnt_d = 16'h0000;
                    st_d = H_START;
                end
            end
            H_START:
            begin
                if (tick)
                begin
                    ph_d = ph_q + 2'h1;
                    case (ph_q)
                        2'h0:
                        begin
                            scl_oe_d = 1'b1;
                            sda_oe_d = 1'b0;
                        end
                        2'h1: scl_oe_d = 1'b0;
                        2'h2: sda_oe_d = 1'b1;
                        default:
                        begin
                            scl_oe_d = 1'b1;
                            bit_d = 4'h0;
                            tx_d = byte_for(step_q, rd_q, addr_q, idx_q, wd_q);
                            st_d = H_BYTE;
                        end
                    endcase
                end
            end
            H_BYTE:
            begin
                if (tick)
                begin
                    ph_d = ph_q + 2'h1;
                    case (ph_q)
                        // (RULE_10) MSB first; ack slot released
                        2'h0: sda_oe_d = (bit_q != BIT_CNT_FULL) && !rdbyte && !tx_q[7];
                        2'h1: ;
                        2'h2: scl_oe_d = 1'b0;
                        default:
                        begin
                            scl_oe_d = 1'b1;
                            bit_d = bit_q + 4'h1;
                            if (bit_q != BIT_CNT_FULL)
                            begin
                                tx_d = {tx_q[6:0], 1'b0};
                                rx_d = {rx_q[6:0], sda_s_q};
                            end
                            // (RULE_06) slave must acknowledge
                            else if (!rdbyte && sda_s_q)
                            begin
                                nack_d = 1'b1;
                                st_d = H_STOP;
                            end
                            else if (rdbyte || (!rd_q && step_q == 3'h2))
                            begin
                                st_d = H_STOP;
                            end
                            else
                            begin
                                // (RULE_12) repeated start before read address
                                step_d = step_q + 3'h1;
                                bit_d = 4'h0;
                                tx_d = byte_for(step_q + 3'h1, rd_q, addr_q, idx_q, wd_q);
                                if (rd_q && step_q == 3'h1)
                                    st_d = H_START;
                            end
                        end
                    endcase
                end
            end
            H_STOP:
            begin
                if (tick)
                begin
                    ph_d = ph_q + 2'h1;
                    case (ph_q)
                        2'h0:
                        begin
                            scl_oe_d = 1'b1;
                            sda_oe_d = 1'b1;
                        end
                        2'h1: scl_oe_d = 1'b0;
                        2'h2: sda_oe_d = 1'b0;
                        default:
                        begin
                            rv_d = 1'b1;
                            ready_d = 1'b1;
                            st_d = H_IDLE;
                        end
                    endcase
                end
            end
            default:
            begin
                st_d = H_IDLE;
                scl_oe_d = 1'b0;
                sda_oe_d = 1'b0;
                ready_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            qcnt_q <= 16'h0000;
            st_q <= H_IDLE;
            ph_q <= 2'h0;
            step_q <= 3'h0;
            bit_q <= 4'h0;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 7'h00;
            idx_q <= 8'h00;
            wd_q <= 8'h00;
            ready_q <= 1'b1;
            rv_q <= 1'b0;
            nack_q <= 1'b0;
        end
        else
        begin
            qcnt_q <= qcnt_d;
            st_q <= st_d;
            ph_q <= ph_d;
            step_q <= step_d;
            bit_q <= bit_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d;
            rd_q <= rd_d;
            addr_q <= addr_d;
            idx_q <= idx_d;
            wd_q <= wd_d;
            ready_q <= ready_d;
            rv_q <= rv_d;
            nack_q <= nack_d;
        end
    end

    // Open-drain outputs pull low only
    assign bus.host_scl_o = 1'b0;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_scl_oe = scl_oe_q;
    assign bus.host_sda_oe = sda_oe_q;
    assign cmd_ready = ready_q;
    assign rsp_valid = rv_q;
    assign rsp_rdata = rx_q;
    assign rsp_nack = nack_q;

endmodule

// ### i2crs_monitor.sv
// Checker of the two-wire link signals
`timescale 1ns/1ps
module i2crs_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic host_scl_o,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Open-drain drivers only pull low
    property p_od; !host_scl_o && !host_sda_o && !dev_sda_o; endproperty
    a_od: assert property (p_od) else $error("pin driven high");
    property p_dev_rise; $rose(dev_sda_oe) |-> !scl; endproperty
    a_dev_rise: assert property (p_dev_rise) else $error("slave took line, clock high");
    property p_dev_hold; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("slave bit moved, clock high");
    property p_dev_late; $changed(dev_sda_oe) |-> !scl && !$past(scl, 2); endproperty
    a_dev_late: assert property (p_dev_late) else $error("slave bit change mistimed");
    property p_start; $fell(sda) && scl |-> host_sda_oe && !dev_sda_oe; endproperty
    a_start: assert property (p_start) else $error("start not from master");
    property p_stop; $rose(sda) && scl |-> $past(host_sda_oe); endproperty
    a_stop: assert property (p_stop) else $error("stop not from master");
    property p_idle; $rose(sda) && scl |=> !dev_sda_oe [*8]; endproperty
    a_idle: assert property (p_idle) else $error("slave drives after stop");
    property p_low; $fell(scl) |-> !scl [*8]; endproperty
    a_low: assert property (p_low) else $error("clock low too short");
endmodule

// ### i2c_register_slave_port_test.sv
// Bench: master and register slave joined on one link
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module i2c_register_slave_port_test;
    import i2crs_pkg::*;
    logic clk, rst, strap0, strap1, mode_pin, two_wire_sel, reg_idx_ok, reg_wr;
    logic cmd_valid, cmd_ready, cmd_read, rsp_valid, rsp_nack, scl_q, sda_q;
    logic [7:0] reg_idx, reg_rdata, reg_wr_idx, reg_wr_data, cmd_idx, cmd_wdata, rsp_rdata;
    logic [6:0] cmd_addr;
    logic [7:0] regs [256];
    logic [31:0] wire_bits;
    int error_cnt, n_tests;
    i2crs_if bus();
    i2crs_device i2crs_device_i (.clk(clk), .rst(rst), .bus(bus), .addr_strap_bit0(strap0),
        .addr_strap_bit1(strap1), .mode_sel_pin(mode_pin), .two_wire_sel(two_wire_sel),
        .reg_idx(reg_idx), .reg_idx_ok(reg_idx_ok), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data));
    i2crs_host #(.QTR_CYCLES(79)) i2crs_host_i (.clk(clk), .rst(rst), .bus(bus),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
        .cmd_addr(cmd_addr), .cmd_idx(cmd_idx), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
    i2crs_monitor i2crs_monitor_i (.clk(clk), .rst(rst), .host_scl_o(bus.host_scl_o),
        .host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe),
        .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));
    // Register file, defined below 40h
    assign reg_rdata = regs[reg_idx];
    assign reg_idx_ok = reg_idx < 8'h40;
    always @(posedge clk)
    begin
        if (reg_wr)
            regs[reg_wr_idx] <= reg_wr_data;
    end
    // Wire sniffer: bits at clock rises, cleared at start
    always @(posedge clk)
    begin
        scl_q <= bus.scl;
        sda_q <= bus.sda;
        if (bus.scl && !scl_q)
            wire_bits <= {wire_bits[30:0], bus.sda};
        else if (bus.scl && scl_q && sda_q && !bus.sda)
            wire_bits <= 32'h0;
    end
    initial
    begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    task automatic complete_run;
        $display("errors=%0d checks=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic do_reset(input logic m);
        rst = 1;
        mode_pin = m;
        repeat (12) @(posedge clk);
        #1 rst = 0;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic rd, input logic [6:0] a, input logic [7:0] ix, wd);
        int i;
        cmd_valid = 1;
        cmd_read = rd;
        cmd_addr = a;
        cmd_idx = ix;
        cmd_wdata = wd;
        @(posedge clk);
        #1 cmd_valid = 0;
        `CHK(cmd_ready, 1'b0)
        for (i = 0; i < 20000 && rsp_valid !== 1'b1; i++)
            @(posedge clk) #1;
        if (i == 20000)
        begin
            error_cnt++;
            complete_run();
        end
        `CHK(cmd_ready, 1'b1)
    endtask
    task automatic t_write;
        cmd(0, 7'h42, 8'h05, 8'h3C);
        `CHK(rsp_nack, 1'b0)
        `CHK(regs[5], 8'h3C)
        `CHK(reg_idx, 8'h06)
        `CHK(wire_bits[27:0], {8'h84, 1'b0, 8'h05, 1'b0, 8'h3C, 2'b00})
    endtask
    task automatic t_read;
        cmd(1, 7'h42, 8'h05, 8'h00);
        `CHK(rsp_rdata, 8'h3C)
        `CHK(wire_bits[18:0], {8'h85, 1'b0, 8'h3C, 2'b10})
    endtask
    task automatic t_refuse;
        cmd(0, 7'h42, 8'h80, 8'h11);
        `CHK(rsp_nack, 1'b1)
        `CHK(regs[8'h80], 8'h00)
        cmd(0, 7'h43, 8'h05, 8'h77);
        `CHK(rsp_nack, 1'b1)
        `CHK(regs[5], 8'h3C)
    endtask
    task automatic t_mode;
        do_reset(1);
        `CHK(two_wire_sel, 1'b0)
        cmd(0, 7'h42, 8'h06, 8'h55);
        `CHK(rsp_nack, 1'b1)
        strap0 = 1;
        strap1 = 0;
        do_reset(0);
        `CHK(two_wire_sel, 1'b1)
        `CHK(reg_idx, 8'h00)
        mode_pin = 1;
        cmd(0, 7'h41, 8'h07, 8'hA5);
        `CHK(rsp_nack, 1'b0)
        `CHK(regs[7], 8'hA5)
        `CHK(reg_idx, 8'h08)
        `CHK(two_wire_sel, 1'b1)
    endtask
    // Main sequence
    initial
    begin
        strap0 = 0;
        strap1 = 1;
        cmd_valid = 0;
        cmd_read = 0;
        cmd_addr = 7'h00;
        cmd_idx = 8'h00;
        cmd_wdata = 8'h00;
        error_cnt = 0;
        n_tests = 0;
        foreach (regs[i])
            regs[i] = 8'h00;
        do_reset(0);
        t_write();
        t_read();
        t_refuse();
        t_mode();
        complete_run();
    end
endmodule
